// File: logic/gdrm_regbank.sv
// Register bank of the isolated gate driver, behind the serial deframer.
// Assumes the deframer presents single-cycle read and write strobes on
// I_CLK with a 7-bit address; fault and drive inputs are asynchronous.
//
// Functional notes
// - primary analog status: dead-time flag bit 1, thermal flag bit 0.
// - primary digital status: fuse flags 7:6, fault flags 3:0.
// - secondary analog status holds eight gate, desaturation_flag, thermal, rail flags.
// - secondary digital status: ECC, program, self-test, CRC, comm flags.
// - two read-only 12-bit duty readbacks, upper bits zero.
// - control: pin-check 7, ECC override 6, program 2, permission 1:0.
// - 8-bit gain trim and 8-bit offset trim registers.
// - 8-bit field disabling the negative-rail undervoltage lockout.
// - config one bit 6 lets short-circuit request override turn-off.
// - config one bit 5 shows desaturation_flag self-test result on fault output.
// - config one bit 4 disables gate-sense gating of desaturation_flag.
// - config one: filter off bit 3, threshold 2:1, bias off bit 0.
// - config two bit 6 routes CRC fault to fault output.
// - config two: blanking select 5:3, lockout threshold 2:0.
// - slew config: turn-on bit 1, turn-off bit 0.
// - read-only 8-bit primary and secondary die identifiers.
// - registers are 15 bits wide and reset to zero.
// - fault bits set on fault, cleared by writing one.
// - status of a side is lost when that side loses power.
// - trim and config writes need both permission bits; programming also needs program bit.

`timescale 1ns/10ps
`default_nettype none

module gdrm_regbank
    import gdrm_pkg::*;
#(
    parameter logic [7:0] PRIM_DIE_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] SEC_DIE_ID  = 8'hA5  // Arbitrary value
)(
    input  wire logic        I_CLK,           // 25 MHz clock
    input  wire logic        I_SRST,          // Synchronous reset, high
    input  wire logic        I_WR,            // Register write strobe
    input  wire logic        I_RD,            // Register read strobe
    input  wire logic [6:0]  I_ADDR,          // Register address
    input  wire logic [14:0] I_WDATA,         // Write data
    input  wire gdrm_async_t I_ASYNC,         // Asynchronous fault inputs
    input  wire logic [11:0] I_DUTY_ONE,      // Channel one duty measure
    input  wire logic [11:0] I_DUTY_TWO,      // Channel two duty measure
    output logic      [14:0] O_RDATA,         // Read data
    output logic             O_RVALID,        // Read data valid pulse
    output logic             O_NVM_PROGRAM,   // Nonvolatile program pulse
    output logic             O_DRIVER_FAULT,  // Driver fault, high active
    output logic             O_GATE_OFF,      // Gate turn-off request
    output logic             O_ASC_ACTIVE,    // Short circuit drive on
    output logic      [7:0]  O_GAIN_TRIM,     // Temp sense gain trim
    output logic      [7:0]  O_OFFSET_TRIM,   // Temp sense offset trim
    output logic      [7:0]  O_LOCKOUT_OFF,   // Negative rail lockout off
    output logic      [7:0]  O_CFG_ONE,       // Protection config one
    output logic      [6:0]  O_CFG_TWO,       // Protection config two
    output logic      [1:0]  O_SLEW,          // Turn-on, turn-off slew
    output logic      [7:0]  O_CONTROL        // Control bits
);

    // ************************************************************
    // Input synchroniser
    // ************************************************************
    gdrm_async_t sync1_reg;
    gdrm_async_t sync2_reg;

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= I_ASYNC;
            sync2_reg <= sync1_reg;
        end
    end

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic [7:0] clear_mask(input logic        we,
                                              input logic [6:0]  addr,
                                              input logic [6:0]  target,
                                              input logic [14:0] data);
        clear_mask = (we && addr == target) ? data[7:0] : 8'h00;
    endfunction : clear_mask

    function automatic logic [7:0] sticky(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic [7:0] clr);
        // Set beats clear so no event is lost in the clearing cycle
        sticky = (cur & ~clr) | set;
    endfunction : sticky

    // ************************************************************
    // Register state
    // ************************************************************
    logic [1:0]  pa_reg, pa_next;
    logic [7:0]  pd_reg, pd_next;
    logic [7:0]  sa_reg, sa_next;
    logic [7:0]  sd_reg, sd_next;
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  gain_reg, gain_next;
    logic [7:0]  offs_reg, offs_next;
    logic [7:0]  lock_reg, lock_next;
    logic [7:0]  cfg1_reg, cfg1_next;
    logic [6:0]  cfg2_reg, cfg2_next;
    logic [1:0]  slew_reg, slew_next;
    logic [14:0] rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;
    logic        prog_reg, prog_next;
    logic        dfault_reg, dfault_next;
    logic        goff_reg, goff_next;
    logic        asc_reg, asc_next;
    logic        wr_open;
    logic        desaturation_flag_q;

    always_comb
    begin
        // Control itself stays writable, otherwise permission could never open
        wr_open   = I_WR && (ctrl_reg[1:0] == CTRL_WRITE_OPEN);
        ctrl_next = ctrl_reg;
        gain_next = gain_reg;
        offs_next = offs_reg;
        lock_next = lock_reg;
        cfg1_next = cfg1_reg;
        cfg2_next = cfg2_reg;
        slew_next = slew_reg;
        if (I_WR && I_ADDR == ADDR_CONTROL)
            ctrl_next = I_WDATA[7:0] & CONTROL_MASK;
        if (wr_open)
        begin
            case (I_ADDR)
                ADDR_GAIN_TRIM:   gain_next = I_WDATA[7:0];
                ADDR_OFFSET_TRIM: offs_next = I_WDATA[7:0];
                ADDR_LOCKOUT_DIS: lock_next = I_WDATA[7:0];
                ADDR_CFG_ONE:     cfg1_next = I_WDATA[7:0];
                ADDR_CFG_TWO:     cfg2_next = I_WDATA[6:0] & CFG_TWO_MASK;
                ADDR_SLEW_CFG:    slew_next = I_WDATA[1:0] & SLEW_MASK;
                default:          ;
            endcase
        end
        // Program pulse only for an accepted write into the user area
        prog_next = wr_open && ctrl_reg[CTRL_PROGRAM]
                    && I_ADDR >= ADDR_GAIN_TRIM && I_ADDR <= ADDR_SLEW_CFG;

        pa_next = 2'(sticky({6'h00, pa_reg}, {6'h00, sync2_reg.prim_analog},
                         clear_mask(I_WR, I_ADDR, ADDR_PRIM_ANALOG, I_WDATA)))
                  & PRIM_ANALOG_MASK;
        pd_next = sticky(pd_reg, sync2_reg.prim_digital,
                         clear_mask(I_WR, I_ADDR, ADDR_PRIM_DIGITAL, I_WDATA))
                  & PRIM_DIGITAL_MASK;
        sa_next = sticky(sa_reg, sync2_reg.sec_analog,
                         clear_mask(I_WR, I_ADDR, ADDR_SEC_ANALOG, I_WDATA));
        sd_next = sticky(sd_reg, sync2_reg.sec_digital,
                         clear_mask(I_WR, I_ADDR, ADDR_SEC_DIGITAL, I_WDATA));
        // Losing a die supply wipes that side's flags
        if (!sync2_reg.prim_ok)
        begin
            pa_next = 2'h0;
            pd_next = 8'h00;
        end
        if (!sync2_reg.sec_ok)
        begin
            sa_next = 8'h00;
            sd_next = 8'h00;
        end

        rvalid_next = I_RD;
        rdata_next  = 15'h0000;
        if (I_RD)
        begin
            case (I_ADDR)
                ADDR_PRIM_ANALOG:  rdata_next = {13'h0000, pa_reg};
                ADDR_PRIM_DIGITAL: rdata_next = {7'h00, pd_reg};
                ADDR_DUTY_ONE:     rdata_next = {3'h0, I_DUTY_ONE};
                ADDR_DUTY_TWO:     rdata_next = {3'h0, I_DUTY_TWO};
                ADDR_PRIM_ID:      rdata_next = {7'h00, PRIM_DIE_ID};
                ADDR_SEC_ANALOG:   rdata_next = {7'h00, sa_reg};
                ADDR_SEC_DIGITAL:  rdata_next = {7'h00, sd_reg};
                ADDR_CONTROL:      rdata_next = {7'h00, ctrl_reg};
                ADDR_GAIN_TRIM:    rdata_next = {7'h00, gain_reg};
                ADDR_OFFSET_TRIM:  rdata_next = {7'h00, offs_reg};
                ADDR_LOCKOUT_DIS:  rdata_next = {7'h00, lock_reg};
                ADDR_CFG_ONE:      rdata_next = {7'h00, cfg1_reg};
                ADDR_CFG_TWO:      rdata_next = {8'h00, cfg2_reg};
                ADDR_SLEW_CFG:     rdata_next = {13'h0000, slew_reg};
                ADDR_SEC_ID:       rdata_next = {7'h00, SEC_DIE_ID};
                default:           rdata_next = 15'h0000;
            endcase
        end

        // Gate-sense gating masks desaturation_flag unless switched off
        desaturation_flag_q = sync2_reg.desaturation_flag
                  && (sync2_reg.gate_sense || cfg1_reg[CFG1_GSR_OFF]);
        asc_next = sync2_reg.active_short_circuit_request;
        // Short circuit request wins over fault turn-off when enabled
        goff_next = (sync2_reg.fault_off || desaturation_flag_q)
                    && !(cfg1_reg[CFG1_ASC_PRIO] && sync2_reg.active_short_circuit_request);
        dfault_next = sync2_reg.drv_fault
                      || (cfg1_reg[CFG1_BIST_OBSERVE] && sync2_reg.desaturation_flag_bist)
                      || (cfg2_reg[CFG2_CRC_ROUTE]
                          && (sync2_reg.prim_digital[DIG_CRC_BIT]
                              || sync2_reg.sec_digital[DIG_CRC_BIT]))
                      || (cfg1_reg[2:1] != 2'h0 && sync2_reg.temp_comp);
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            pa_reg     <= REG_RESET[1:0];
            pd_reg     <= REG_RESET[7:0];
            sa_reg     <= REG_RESET[7:0];
            sd_reg     <= REG_RESET[7:0];
            ctrl_reg   <= REG_RESET[7:0];
            gain_reg   <= REG_RESET[7:0];
            offs_reg   <= REG_RESET[7:0];
            lock_reg   <= REG_RESET[7:0];
            cfg1_reg   <= REG_RESET[7:0];
            cfg2_reg   <= CFG_TWO_RESET;
            slew_reg   <= REG_RESET[1:0];
            rdata_reg  <= REG_RESET;
            rvalid_reg <= 1'b0;
            prog_reg   <= 1'b0;
            dfault_reg <= 1'b0;
            goff_reg   <= 1'b0;
            asc_reg    <= 1'b0;
        end
        else
        begin
            pa_reg     <= pa_next;
            pd_reg     <= pd_next;
            sa_reg     <= sa_next;
            sd_reg     <= sd_next;
            ctrl_reg   <= ctrl_next;
            gain_reg   <= gain_next;
            offs_reg   <= offs_next;
            lock_reg   <= lock_next;
            cfg1_reg   <= cfg1_next;
            cfg2_reg   <= cfg2_next;
            slew_reg   <= slew_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            prog_reg   <= prog_next;
            dfault_reg <= dfault_next;
            goff_reg   <= goff_next;
            asc_reg    <= asc_next;
        end
    end

    assign O_RDATA        = rdata_reg;
    assign O_RVALID       = rvalid_reg;
    assign O_NVM_PROGRAM  = prog_reg;
    assign O_DRIVER_FAULT = dfault_reg;
    assign O_GATE_OFF     = goff_reg;
    assign O_ASC_ACTIVE   = asc_reg;
    assign O_GAIN_TRIM    = gain_reg;
    assign O_OFFSET_TRIM  = offs_reg;
    assign O_LOCKOUT_OFF  = lock_reg;
    assign O_CFG_ONE      = cfg1_reg;
    assign O_CFG_TWO      = cfg2_reg;
    assign O_SLEW         = slew_reg;
    assign O_CONTROL      = ctrl_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    property p_write_locked;
        I_WR && I_ADDR == ADDR_CFG_ONE && ctrl_reg[1:0] != CTRL_WRITE_OPEN
            |=> $stable(O_CFG_ONE);
    endproperty
    a_write_locked: assert property (p_write_locked)
        else $error("Config written without permission");

    property p_write_open;
        I_WR && I_ADDR == ADDR_SLEW_CFG && ctrl_reg[1:0] == CTRL_WRITE_OPEN
            |=> O_SLEW == $past(I_WDATA[1:0]);
    endproperty
    a_write_open: assert property (p_write_open)
        else $error("Slew write not stored");

    property p_set_wins;
        sync2_reg.sec_ok && sync2_reg.sec_analog[5] |=> sa_reg[5];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Desaturation_flag flag lost");

    property p_clear_one;
        I_WR && I_ADDR == ADDR_SEC_DIGITAL && I_WDATA[0] && !sync2_reg.sec_digital[0]
            |=> !sd_reg[0];
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("Write one did not clear flag");

    property p_volatile;
        !sync2_reg.prim_ok |=> pa_reg == 2'h0 && pd_reg == 8'h00;
    endproperty
    a_volatile: assert property (p_volatile)
        else $error("Primary flags kept without power");

    property p_asc_prio;
        cfg1_reg[CFG1_ASC_PRIO] && sync2_reg.active_short_circuit_request |=> !O_GATE_OFF ##0 O_ASC_ACTIVE;
    endproperty
    a_asc_prio: assert property (p_asc_prio)
        else $error("Turn-off beat short circuit request");

    property p_crc_route;
        cfg2_reg[CFG2_CRC_ROUTE] && sync2_reg.sec_digital[DIG_CRC_BIT] |=> O_DRIVER_FAULT;
    endproperty
    a_crc_route: assert property (p_crc_route)
        else $error("CRC fault not routed");

    property p_reserved_zero;
        I_RD |=> O_RVALID && O_RDATA[14:12] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved bits read nonzero");

    property p_program;
        O_NVM_PROGRAM |-> $past(ctrl_reg[CTRL_PROGRAM]) && $past(ctrl_reg[1:0]) == 2'h3;
    endproperty
    a_program: assert property (p_program)
        else $error("Program without permission");

    property p_gsr_gate;
        !cfg1_reg[CFG1_GSR_OFF] && !sync2_reg.gate_sense && !sync2_reg.fault_off
            |=> !O_GATE_OFF;
    endproperty
    a_gsr_gate: assert property (p_gsr_gate)
        else $error("Desaturation_flag acted without gate sense");

    property p_control_write;
        I_WR && I_ADDR == ADDR_CONTROL |=> O_CONTROL == ($past(I_WDATA[7:0]) & CONTROL_MASK);
    endproperty
    a_control_write: assert property (p_control_write)
        else $error("Control write not stored");

    property p_bist_observe;
        cfg1_reg[CFG1_BIST_OBSERVE] && sync2_reg.desaturation_flag_bist |=> O_DRIVER_FAULT;
    endproperty
    a_bist_observe: assert property (p_bist_observe)
        else $error("Self-test result not shown on fault output");

    property p_temp_route;
        cfg1_reg[2:1] != 2'h0 && sync2_reg.temp_comp |=> O_DRIVER_FAULT;
    endproperty
    a_temp_route: assert property (p_temp_route)
        else $error("Temperature threshold fault not routed");

    property p_die_id;
        I_RD && I_ADDR == ADDR_SEC_ID |=> O_RDATA == {7'h00, SEC_DIE_ID};
    endproperty
    a_die_id: assert property (p_die_id)
        else $error("Secondary identifier read wrong");

    property p_volatile_sec;
        !sync2_reg.sec_ok |=> sa_reg == 8'h00 && sd_reg == 8'h00;
    endproperty
    a_volatile_sec: assert property (p_volatile_sec)
        else $error("Secondary flags kept without power");

    c_program:  cover property (O_NVM_PROGRAM);
    c_clear:    cover property (sa_reg[5] ##1 !sa_reg[5]);
    c_asc_over: cover property (O_ASC_ACTIVE && cfg1_reg[CFG1_ASC_PRIO]);
    c_locked:   cover property (I_WR && I_ADDR == ADDR_GAIN_TRIM && !ctrl_reg[0]);
    c_sec_lost: cover property (!sync2_reg.sec_ok && sa_reg != 8'h00);

endmodule : gdrm_regbank

`default_nettype wire

// File: logic/gdrm_pkg.sv
// Package for the gate driver register bank: offsets, field positions,
// reset values and the carrier struct for the asynchronous fault inputs.
// Assumes a 15-bit register word and a 7-bit register address.
package gdrm_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [6:0] ADDR_PRIM_ANALOG  = 7'h00;
    localparam logic [6:0] ADDR_PRIM_DIGITAL = 7'h01;
    localparam logic [6:0] ADDR_DUTY_ONE     = 7'h08;
    localparam logic [6:0] ADDR_DUTY_TWO     = 7'h09;
    localparam logic [6:0] ADDR_PRIM_ID      = 7'h3F;
    localparam logic [6:0] ADDR_SEC_ANALOG   = 7'h40;
    localparam logic [6:0] ADDR_SEC_DIGITAL  = 7'h41;
    localparam logic [6:0] ADDR_CONTROL      = 7'h42;
    localparam logic [6:0] ADDR_GAIN_TRIM    = 7'h50;
    localparam logic [6:0] ADDR_OFFSET_TRIM  = 7'h51;
    localparam logic [6:0] ADDR_LOCKOUT_DIS  = 7'h52;
    localparam logic [6:0] ADDR_CFG_ONE      = 7'h53;
    localparam logic [6:0] ADDR_CFG_TWO      = 7'h54;
    localparam logic [6:0] ADDR_SLEW_CFG     = 7'h55;
    localparam logic [6:0] ADDR_SEC_ID       = 7'h7F;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam logic [1:0]  PRIM_ANALOG_MASK  = 2'h3;
    localparam logic [7:0]  PRIM_DIGITAL_MASK = 8'hCF;
    localparam logic [7:0]  CONTROL_MASK      = 8'hC7;
    localparam logic [6:0]  CFG_TWO_MASK      = 7'h7F;
    localparam logic [1:0]  SLEW_MASK         = 2'h3;
    localparam int          CTRL_PIN_CHECK    = 7;
    localparam int          CTRL_ECC_OVERRIDE = 6;
    localparam int          CTRL_PROGRAM      = 2;
    localparam logic [1:0]  CTRL_WRITE_OPEN   = 2'h3;
    localparam int          CFG1_ASC_PRIO     = 6;
    localparam int          CFG1_BIST_OBSERVE = 5;
    localparam int          CFG1_GSR_OFF      = 4;
    localparam int          CFG1_FILTER_OFF   = 3;
    localparam int          CFG1_BIAS_OFF     = 0;
    localparam int          CFG2_CRC_ROUTE    = 6;
    localparam int          DIG_CRC_BIT       = 1;
    localparam logic [14:0] REG_RESET         = 15'h0000;
    localparam logic [6:0]  CFG_TWO_RESET     = 7'h00;

    // Fault and drive inputs that arrive from the analog side
    typedef struct packed {
        logic       prim_ok;
        logic       sec_ok;
        logic [1:0] prim_analog;
        logic [7:0] prim_digital;
        logic [7:0] sec_analog;
        logic [7:0] sec_digital;
        logic       desaturation_flag;
        logic       gate_sense;
        logic       active_short_circuit_request;
        logic       fault_off;
        logic       temp_comp;
        logic       desaturation_flag_bist;
        logic       drv_fault;
    } gdrm_async_t;

endpackage : gdrm_pkg

// File: tb/gdrm_host_model.sv
// Host model: master of the register strobe bus of the register bank.
// Assumes the bench owns the clock and calls wr_reg and rd_reg.
`timescale 1ns/10ps
`default_nettype none
module gdrm_host_model (
    input  wire logic        i_clk,    // Bus clock
    input  wire logic        i_rvalid, // Read data valid
    input  wire logic [14:0] i_rdata,  // Read data
    output var  logic        o_wr,     // Write strobe
    output var  logic        o_rd,     // Read strobe
    output var  logic [6:0]  o_addr,   // Address
    output var  logic [14:0] o_wdata   // Write data
);
    int to_cnt = 0;

    initial
    begin
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = 7'h00;
        o_wdata = 15'h0000;
    end

    // Released lines show the inverse, so a stale value never looks valid
    task automatic wr_reg(input logic [6:0] a, input logic [14:0] d);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [6:0] a, output logic [14:0] d);
        int n;
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        n = 0;
        while (i_rvalid !== 1'b1 && n < 4)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 4)
            to_cnt++;
        d = i_rdata;
    endtask : rd_reg
endmodule : gdrm_host_model
`default_nettype wire

// File: tb/gate_driver_spi_register_map_bench.sv
// Self-checking bench of the register bank, random with fixed seed.
// Assumes gdrm_pkg and the host model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module gate_driver_spi_register_map_bench;
    import gdrm_pkg::*;
    localparam logic [7:0] ID_P = 8'h3C; // Arbitrary value
    localparam logic [7:0] ID_S = 8'hC3; // Arbitrary value
    localparam logic [6:0] RL [16] = '{7'h00, 7'h01, 7'h08, 7'h09, 7'h3F, 7'h40, 7'h41,
        7'h42, 7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h7F, 7'h10};
    localparam logic [6:0] FL [4] = '{7'h00, 7'h01, 7'h40, 7'h41};
    logic        clk, srst, wr, rd, rv, prg, drv_f, goff, asca;
    logic [6:0]  addr, cfg2, c2;
    logic [14:0] wd, rdat, v, c;
    logic [11:0] d1, d2;
    logic [7:0]  gain, offs, lock, cfg1, ctrl, c1, iv;
    logic [1:0]  slew;
    logic [14:0] sh [128];
    gdrm_async_t asy;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          prog_cnt = 0;
    int          p0;

    gdrm_regbank #(.PRIM_DIE_ID(ID_P), .SEC_DIE_ID(ID_S)) uut (
        .I_CLK(clk), .I_SRST(srst), .I_WR(wr), .I_RD(rd), .I_ADDR(addr), .I_WDATA(wd),
        .I_ASYNC(asy), .I_DUTY_ONE(d1), .I_DUTY_TWO(d2), .O_RDATA(rdat), .O_RVALID(rv),
        .O_NVM_PROGRAM(prg), .O_DRIVER_FAULT(drv_f), .O_GATE_OFF(goff),
        .O_ASC_ACTIVE(asca), .O_GAIN_TRIM(gain), .O_OFFSET_TRIM(offs),
        .O_LOCKOUT_OFF(lock), .O_CFG_ONE(cfg1), .O_CFG_TWO(cfg2), .O_SLEW(slew),
        .O_CONTROL(ctrl));
    gdrm_host_model host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wd));

    // ************************************************************
    // Expectations and checks
    // ************************************************************
    function automatic logic [14:0] rst_val(logic [6:0] a);
        case (a)
            ADDR_DUTY_ONE: return {3'h0, d1};
            ADDR_DUTY_TWO: return {3'h0, d2};
            ADDR_PRIM_ID:  return {7'h00, ID_P};
            ADDR_SEC_ID:   return {7'h00, ID_S};
            default:       return 15'h0000;
        endcase
    endfunction : rst_val

    function automatic logic [14:0] wmask(logic [6:0] a);
        case (a)
            ADDR_CFG_TWO:  return 15'h007F;
            ADDR_SLEW_CFG: return 15'h0003;
            default:       return 15'h00FF;
        endcase
    endfunction : wmask

    function automatic logic [14:0] fmask(logic [6:0] a);
        return (a == ADDR_PRIM_ANALOG) ? 15'h0003 : (a == ADDR_PRIM_DIGITAL) ? 15'h00CF : 15'h00FF;
    endfunction : fmask

    function automatic logic exp_go(logic [7:0] k, logic [7:0] x);
        return (x[4] | (x[7] & (x[6] | k[4]))) & ~(k[6] & x[5]);
    endfunction : exp_go

    function automatic logic exp_df(logic [7:0] k, logic [6:0] k2, logic [7:0] x);
        return x[1] | (k[5] & x[2]) | (k2[6] & x[0]) | ((k[2:1] != 2'h0) & x[3]);
    endfunction : exp_df

    task automatic chk_word(input string nm, input logic [14:0] e, input logic [14:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic rd_chk(input logic [6:0] a, input logic [14:0] e);
        logic [14:0] d;
        host.rd_reg(a, d);
        chk_word($sformatf("reg %h", a), e, d);
    endtask : rd_chk

    // Fault events enter at the analog side inputs, bit for bit
    task automatic set_flags(input logic [6:0] a, input logic [7:0] x);
        @(posedge clk);
        case (a)
            ADDR_PRIM_ANALOG:  asy.prim_analog <= x[1:0];
            ADDR_PRIM_DIGITAL: asy.prim_digital <= x;
            ADDR_SEC_ANALOG:   asy.sec_analog <= x;
            default:           asy.sec_digital <= x;
        endcase
    endtask : set_flags

    task automatic give_verdict();
        error_cnt += host.to_cnt;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // ************************************************************
    // Clock, watchdog and sequence
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
        if (prg === 1'b1)
            prog_cnt++;

    initial
    begin
        #(40 * 20000);
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        srst = 1'b1;
        asy = '0;
        asy.prim_ok = 1'b1;
        asy.sec_ok = 1'b1;
        d1 = 12'h000;
        d2 = 12'h000;
        void'($urandom(32'hb46d));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        d1 <= 12'($urandom);
        d2 <= 12'($urandom);
        #1;
        chk_word("ctrl_out", 15'h0000, {7'h00, ctrl});
        foreach (RL[i]) rd_chk(RL[i], rst_val(RL[i]));
        host.wr_reg(ADDR_GAIN_TRIM, 15'h00FF);
        rd_chk(ADDR_GAIN_TRIM, 15'h0000);
        host.wr_reg(ADDR_CONTROL, 15'h7FFF);
        rd_chk(ADDR_CONTROL, 15'h00C7);
        host.wr_reg(ADDR_CONTROL, 15'h0003);
        repeat (4)
            for (int a = 8'h50; a <= 8'h55; a++)
            begin
                v = 15'($urandom);
                sh[a] = v & wmask(7'(a));
                host.wr_reg(7'(a), v);
                rd_chk(7'(a), sh[a]);
            end
        chk_word("gain", sh[8'h50], {7'h00, gain});
        chk_word("offset", sh[8'h51], {7'h00, offs});
        chk_word("lockout", sh[8'h52], {7'h00, lock});
        chk_word("cfg_one", sh[8'h53], {7'h00, cfg1});
        chk_word("cfg_two", sh[8'h54], {8'h00, cfg2});
        chk_word("slew", sh[8'h55], {13'h0000, slew});
        // Program pulse only with permission and program bit together
        p0 = prog_cnt;
        host.wr_reg(ADDR_CONTROL, 15'h0007);
        host.wr_reg(ADDR_SLEW_CFG, 15'h0002);
        host.wr_reg(ADDR_CONTROL, 15'h0004);
        host.wr_reg(ADDR_GAIN_TRIM, 15'h0055);
        repeat (3) @(posedge clk);
        chk_word("prog_cnt", 15'(p0 + 1), 15'(prog_cnt));
        rd_chk(ADDR_GAIN_TRIM, sh[8'h50]);
        host.wr_reg(ADDR_CONTROL, 15'h0003);
        foreach (FL[i])
        begin
            v = {7'h00, 8'($urandom)};
            set_flags(FL[i], v[7:0]);
            set_flags(FL[i], 8'h00);
            repeat (4) @(posedge clk);
            rd_chk(FL[i], v & fmask(FL[i]));
            c = {7'h00, 8'($urandom)};
            host.wr_reg(FL[i], c);
            rd_chk(FL[i], v & fmask(FL[i]) & ~c);
            host.wr_reg(FL[i], 15'h7FFF);
            rd_chk(FL[i], 15'h0000);
        end
        set_flags(ADDR_SEC_ANALOG, 8'h20);
        set_flags(ADDR_PRIM_ANALOG, 8'h01);
        set_flags(ADDR_SEC_ANALOG, 8'h00);
        set_flags(ADDR_PRIM_ANALOG, 8'h00);
        asy.sec_ok <= 1'b0;
        repeat (6) @(posedge clk);
        asy.sec_ok <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(ADDR_SEC_ANALOG, 15'h0000);
        rd_chk(ADDR_PRIM_ANALOG, 15'h0001);
        // Drive inputs: desaturation_flag, sense, asc, off, temp, self_test_fault_flag, crc
        for (int i = 0; i < 16; i++)
        begin
            {c1, c2, iv} = 23'($urandom);
            if (i == 0)
                {c1, iv} = {8'h40, 8'hE0};
            if (i == 1)
                {c1, iv} = {8'h10, 8'h80};
            host.wr_reg(ADDR_CFG_ONE, {7'h00, c1});
            host.wr_reg(ADDR_CFG_TWO, {8'h00, c2});
            @(posedge clk);
            {asy.desaturation_flag, asy.gate_sense, asy.active_short_circuit_request, asy.fault_off} <= iv[7:4];
            {asy.temp_comp, asy.desaturation_flag_bist, asy.drv_fault} <= iv[3:1];
            asy.prim_digital <= {6'h00, iv[0], 1'b0};
            repeat (5) @(posedge clk);
            #1;
            chk_bit("gate_off", exp_go(c1, iv), goff);
            chk_bit("drv_fault", exp_df(c1, c2, iv), drv_f);
            chk_word("cfg_two_out", {8'h00, c2}, {8'h00, cfg2});
            chk_bit("asc_active", iv[5], asca);
        end
        give_verdict();
    end
endmodule : gate_driver_spi_register_map_bench
`default_nettype wire
